/* File: hdl/utopia_emac_pin_sharing.sv */
// Shared pin logic: cell slave port or Ethernet media interface
`timescale 1ns/10ps
module utopia_emac_pin_sharing (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// Straps
	input  wire logic       cell_port_select_strap,
	input  wire logic [1:0] eth_iface_select_strap,
	// Shared pins
	input  wire logic       cell_rx_clk,
	input  wire logic [7:0] cell_rx_byte,
	output logic            tx_cell_ready,
	output logic            tx_cell_ready_oe_b,
	input  wire logic       cell_tx_clk,
	output logic            tx_cell_first_byte,
	output logic            tx_cell_first_byte_oe_b,
	input  wire logic       tx_cell_first_byte_in,
	output logic [7:0]      cell_tx_byte,
	output logic            cell_tx_byte_oe_b,
	// Cell receive stream to the core
	output logic [7:0]      rx_byte,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic            rx_overrun,
	// Cell transmit stream from the core
	input  wire logic       core_cell_waiting,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_first,
	input  wire logic       tx_valid,
	output logic            tx_take,
	// Ethernet side towards the MAC
	input  wire logic       gig_tx_clk_src,
	output logic            eth_rx_clk,
	output logic [7:0]      eth_rx_nibble_byte,
	output logic [1:0]      eth_reduced_rx_bits,
	output logic            eth_tx_clk_in,
	output logic            reduced_ref_clk,
	output logic            eth_collision_in,
	// Mode reporting
	output logic            cell_mode,
	output pin_share_pkg::eth_iface_t eth_iface
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic       strap_cell_s1;
	logic       strap_cell_s2;
	logic [1:0] strap_if_s1;
	logic [1:0] strap_if_s2;
	logic       rx_clk_s1;
	logic       rx_clk_s2;
	logic       rx_clk_s3;
	logic [7:0] rx_data_s1;
	logic [7:0] rx_data_s2;
	logic       tx_clk_s1;
	logic       tx_clk_s2;
	logic       tx_clk_s3;
	logic       col_s1;
	logic       col_s2;

	always_ff @(posedge sys_clk) begin
		strap_cell_s1 <= cell_port_select_strap;
		strap_cell_s2 <= strap_cell_s1;
		strap_if_s1   <= eth_iface_select_strap;
		strap_if_s2   <= strap_if_s1;
		rx_clk_s1     <= cell_rx_clk;
		rx_clk_s2     <= rx_clk_s1;
		rx_clk_s3     <= rx_clk_s2;
		rx_data_s1    <= cell_rx_byte;
		rx_data_s2    <= rx_data_s1;
		tx_clk_s1     <= cell_tx_clk;
		tx_clk_s2     <= tx_clk_s1;
		tx_clk_s3     <= tx_clk_s2;
		col_s1        <= tx_cell_first_byte_in;
		col_s2        <= col_s1;
	end

	// ------------------------------------------------------------
	// Strap capture after reset release
	// ------------------------------------------------------------
	logic strap_taken;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			strap_taken <= 1'b0;
			cell_mode   <= pin_share_pkg::CELL_MODE_RESET;
			eth_iface   <= pin_share_pkg::IFACE_RESET;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			cell_mode   <= strap_cell_s2;
			eth_iface   <= pin_share_pkg::eth_iface_t'(strap_if_s2);
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire eth_mode   = !cell_mode;
	wire sel_mii    = eth_mode && (eth_iface == pin_share_pkg::IFACE_MII);
	wire sel_rmii   = eth_mode && (eth_iface == pin_share_pkg::IFACE_RMII);
	wire sel_gmii   = eth_mode && (eth_iface == pin_share_pkg::IFACE_GMII);
	wire mii_or_gig = sel_mii || sel_gmii;
	wire rx_rise    = rx_clk_s2 && !rx_clk_s3;
	wire tx_rise    = tx_clk_s2 && !tx_clk_s3;

	// ------------------------------------------------------------
	// Cell receive capture into the FIFO
	// ------------------------------------------------------------
	byte_stream_if rx_stream ();

	logic [7:0] cap_byte;
	logic       cap_valid;

	wire cap_now = cell_mode && rx_rise;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cap_byte  <= pin_share_pkg::BYTE_RESET;
			cap_valid <= 1'b0;
		end else if (cap_now) begin
			cap_byte  <= rx_data_s2;
			cap_valid <= 1'b1;
		end else if (rx_stream.ready) begin
			cap_valid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rx_overrun <= 1'b0;
		end else begin
			rx_overrun <= cap_now && cap_valid && !rx_stream.ready;
		end
	end

	assign rx_stream.data  = cap_byte;
	assign rx_stream.valid = cap_valid;

	byte_fifo #(
		.WIDTH (pin_share_pkg::BYTE_W),
		.DEPTH (pin_share_pkg::FIFO_DEPTH)
	) rx_fifo (
		.sys_clk     (sys_clk),
		.rst_b       (rst_b),
		.fill        (rx_stream),
		.drain_data  (rx_byte),
		.drain_valid (rx_valid),
		.drain_ready (rx_ready)
	);

	// ------------------------------------------------------------
	// Cell transmit side
	// ------------------------------------------------------------
	assign tx_take = cell_mode && tx_rise && tx_valid;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cell_tx_byte       <= pin_share_pkg::BYTE_RESET;
			tx_cell_first_byte <= 1'b0;
		end else if (cell_mode && tx_rise) begin
			cell_tx_byte       <= tx_valid ? tx_byte : pin_share_pkg::BYTE_RESET;
			tx_cell_first_byte <= tx_valid && tx_first;
		end
	end

	logic cell_ready_q;
	logic gig_clk_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cell_ready_q <= 1'b0;
			gig_clk_q    <= 1'b0;
		end else begin
			cell_ready_q <= cell_mode && core_cell_waiting;
			gig_clk_q    <= sel_gmii && gig_tx_clk_src;
		end
	end

	// ------------------------------------------------------------
	// Shared output pins and their enables
	// ------------------------------------------------------------
	assign tx_cell_ready           = cell_mode ? cell_ready_q : gig_clk_q;
	assign tx_cell_ready_oe_b      = !(cell_mode || sel_gmii);
	assign tx_cell_first_byte_oe_b = !cell_mode;
	assign cell_tx_byte_oe_b       = !cell_mode;

	// ------------------------------------------------------------
	// Ethernet inputs, held low unless selected
	// ------------------------------------------------------------
	logic [7:0] eth_rx_q;
	logic [1:0] eth_rmii_q;
	logic       eth_rx_clk_q;
	logic       eth_tx_clk_q;
	logic       ref_clk_q;
	logic       col_q;

	wire [7:0] rx_width_mask = sel_gmii ? 8'hff : (sel_mii ? 8'h0f : 8'h00);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			eth_rx_q     <= pin_share_pkg::BYTE_RESET;
			eth_rmii_q   <= 2'h0;
			eth_rx_clk_q <= 1'b0;
			eth_tx_clk_q <= 1'b0;
			ref_clk_q    <= 1'b0;
			col_q        <= 1'b0;
		end else begin
			eth_rx_q     <= rx_data_s2 & rx_width_mask;
			eth_rmii_q   <= sel_rmii ? rx_data_s2[1:0] : 2'h0;
			eth_rx_clk_q <= mii_or_gig && rx_clk_s2;
			eth_tx_clk_q <= mii_or_gig && tx_clk_s2;
			ref_clk_q    <= sel_rmii && tx_clk_s2;
			col_q        <= mii_or_gig && col_s2;
		end
	end

	assign eth_rx_nibble_byte  = eth_rx_q;
	assign eth_reduced_rx_bits = eth_rmii_q;
	assign eth_rx_clk          = eth_rx_clk_q;
	assign eth_tx_clk_in       = eth_tx_clk_q;
	assign reduced_ref_clk     = ref_clk_q;
	assign eth_collision_in    = col_q;

endmodule : utopia_emac_pin_sharing

/* File: hdl/pin_share_pkg.sv */
// Constants and types shared by the cell-port / Ethernet pin sharing logic
// How it works
// - After reset without strap override, shared pins carry the cell port, receive bus input.
// - In cell mode, receive bytes are captured on each rising receive clock edge.
// - Strap low: receive pins become Ethernet receive data, width set by interface strap.
// - Cell-available output is 1 when a full cell waits, 0 otherwise.
// - Strap low with GMII selected: cell-available pin instead outputs the gigabit transmit clock.
// - Strap low: transmit clock pin is the Ethernet transmit clock input for MII or GMII, the reduced reference clock input for RMII.
// - First-byte flag rises with the first cell byte on the transmit clock edge.
// - Strap low: first-byte pin becomes the collision input for MII or GMII.
package pin_share_pkg;

	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned MII_W      = 4;
	localparam int unsigned RMII_W     = 2;

	// ------------------------------------------------------------
	// Ethernet interface select strap codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		IFACE_MII   = 2'h0,
		IFACE_RMII  = 2'h1,
		IFACE_GMII  = 2'h2,
		IFACE_RGMII = 2'h3
	} eth_iface_t;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic       CELL_MODE_RESET = 1'b1;
	localparam eth_iface_t IFACE_RESET     = IFACE_MII;
	localparam logic [7:0] BYTE_RESET      = 8'h00;

endpackage : pin_share_pkg

/* File: hdl/byte_stream_if.sv */
// Valid/ready byte stream carrier between the pin logic and its FIFO
`timescale 1ns/10ps
interface byte_stream_if;
	logic [7:0] data;
	logic       valid;
	logic       ready;

	modport source (output data, output valid, input ready);
	modport sink   (input data, input valid, output ready);
endinterface : byte_stream_if

/* File: hdl/byte_fifo.sv */
// Parameterised FIFO with a registered read stage
`timescale 1ns/10ps
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	byte_stream_if.sink           fill,
	output logic      [WIDTH-1:0] drain_data,
	output logic                  drain_valid,
	input  wire logic             drain_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire full  = (count == (AW+1)'(DEPTH));
	wire empty = (count == '0);
	wire push  = fill.valid && !full;
	wire load  = !empty && (!drain_valid || drain_ready);

	assign fill.ready = !full;

	// ------------------------------------------------------------
	// Write side
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= fill.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (load) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// ------------------------------------------------------------
	// Registered read stage
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			drain_data  <= '0;
			drain_valid <= 1'b0;
		end else if (load) begin
			drain_data  <= mem[rd_ptr];
			drain_valid <= 1'b1;
		end else if (drain_ready) begin
			drain_valid <= 1'b0;
		end
	end

endmodule : byte_fifo

/* File: tb/pin_share_properties.sv */
// Concurrent checks on the shared pin block ports
`timescale 1ns/10ps
module pin_share_properties (
	input logic       sys_clk,
	input logic       rst_b,
	input logic       cell_port_select_strap,
	input logic [1:0] eth_iface_select_strap,
	input logic [7:0] cell_rx_byte,
	input logic       cell_rx_clk,
	input logic       cell_tx_clk,
	input logic       tx_cell_first_byte_in,
	input logic       core_cell_waiting,
	input logic [7:0] tx_byte,
	input logic       tx_first,
	input logic       tx_valid,
	input logic       gig_tx_clk_src,
	input logic       tx_cell_ready,
	input logic       tx_cell_ready_oe_b,
	input logic       tx_cell_first_byte,
	input logic       tx_cell_first_byte_oe_b,
	input logic [7:0] cell_tx_byte,
	input logic       cell_tx_byte_oe_b,
	input logic       tx_take,
	input logic [7:0] eth_rx_nibble_byte,
	input logic       eth_rx_clk,
	input logic [1:0] eth_reduced_rx_bits,
	input logic       eth_tx_clk_in,
	input logic       reduced_ref_clk,
	input logic       eth_collision_in,
	input logic       cell_mode,
	input pin_share_pkg::eth_iface_t eth_iface
);
	// ------
	// Helpers
	// ------
	logic [1:0] eth_age;
	wire        gm   = eth_iface == pin_share_pkg::IFACE_GMII;
	wire        mi   = eth_iface == pin_share_pkg::IFACE_MII;
	wire        rm   = eth_iface == pin_share_pkg::IFACE_RMII;
	wire        eth3 = eth_age == 2'h3;
	wire  [7:0] msk  = gm ? 8'hff : (mi ? 8'h0f : 8'h00);
	// Cycles spent in Ethernet mode, saturating
	always_ff @(posedge sys_clk) begin
		eth_age <= (!rst_b || cell_mode) ? 2'h0 : eth_age + {1'b0, eth_age != 2'h3};
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ------
	// Assertions
	// ------
	strap_mode_a: assert property ($past(rst_b, 2) |-> cell_mode == cell_port_select_strap
		&& (cell_mode || eth_iface == eth_iface_select_strap)) else $error("mode differs from straps");
	cell_ready_a: assert property (cell_mode && $past(cell_mode) && $past(rst_b)
		|-> tx_cell_ready == $past(core_cell_waiting)) else $error("cell-available wrong");
	gig_clk_a: assert property (!cell_mode && !$past(cell_mode) && gm && $past(rst_b)
		|-> tx_cell_ready == $past(gig_tx_clk_src)) else $error("gigabit clock copy wrong");
	pin_enable_a: assert property (tx_cell_ready_oe_b == !(cell_mode || gm)
		&& tx_cell_first_byte_oe_b == !cell_mode && cell_tx_byte_oe_b == !cell_mode)
		else $error("output enable wrong");
	rx_width_a: assert property (eth3 |-> eth_rx_nibble_byte == ($past(cell_rx_byte, 3) & msk))
		else $error("eth receive data wrong");
	tx_clk_a: assert property (eth3 |-> eth_tx_clk_in == ($past(cell_tx_clk, 3) && (mi || gm))
		&& reduced_ref_clk == ($past(cell_tx_clk, 3) && rm)) else $error("eth tx clock wrong");
	rx_clk_a: assert property (eth3
		|-> eth_rx_clk == ($past(cell_rx_clk, 3) && (mi || gm))
		&& eth_reduced_rx_bits == ($past(cell_rx_byte[1:0], 3) & {2{rm}}))
		else $error("eth receive clock or bits wrong");
	collision_in_a: assert property (eth3
		|-> eth_collision_in == ($past(tx_cell_first_byte_in, 3) && (mi || gm)))
		else $error("collision input wrong");
	first_byte_a: assert property (tx_take |=> cell_tx_byte == $past(tx_byte)
		&& tx_cell_first_byte == $past(tx_first)) else $error("transmit byte or flag wrong");
	take_gate_a: assert property (tx_take == (cell_mode && tx_valid
		&& $past(cell_tx_clk, 2) && !$past(cell_tx_clk, 3)))
		else $error("take outside a cell transmit clock rise");
	idle_byte_a: assert property (cell_mode && !tx_valid && $past(cell_tx_clk, 2)
		&& !$past(cell_tx_clk, 3) |=> cell_tx_byte == 8'h00 && !tx_cell_first_byte)
		else $error("idle transmit byte not cleared");
	eth_idle_a: assert property (cell_mode |-> eth_rx_nibble_byte == 8'h00
		&& !eth_collision_in && !eth_tx_clk_in && !reduced_ref_clk && !eth_rx_clk
		&& eth_reduced_rx_bits == 2'h0) else $error("eth side active");
	cover property (tx_take && tx_first);
	cover property (eth3 && gm);
	cover property (cell_mode && tx_cell_ready);
	cover property (eth3 && rm && reduced_ref_clk);
endmodule : pin_share_properties

bind utopia_emac_pin_sharing pin_share_properties pin_share_properties_i (.*);

/* File: tb/cell_master.sv */
// Master cell controller model: frame clocks and receive bytes
`timescale 1ns/10ps
module cell_master (
	input  logic       go,
	input  logic [7:0] n_bytes,
	output logic       cell_rx_clk,
	output logic       cell_tx_clk,
	output logic [7:0] cell_rx_byte
);
	// ------
	// Frames
	// ------
	initial begin
		cell_rx_clk = 1'b0;
		cell_tx_clk = 1'b0;
		cell_rx_byte = 8'h5a;
		forever begin
			@(posedge go);
			#3.1;
			for (int i = 0; i < n_bytes; i++) begin
				cell_rx_byte = i[7:0];
				#62.5 cell_rx_clk = 1'b1;
				cell_tx_clk = 1'b1;
				#62.5 cell_rx_clk = 1'b0;
				cell_tx_clk = 1'b0;
			end
			// Released bus shows the inverse
			cell_rx_byte = ~cell_rx_byte;
		end
	end
endmodule : cell_master

/* File: tb/tb_top.sv */
// Self-checking bench for the shared pin block
`timescale 1ns/10ps
module tb_top;
	logic                      sys_clk, rst_b, sel, rx_ready, go, cell_rx_clk, cell_tx_clk;
	logic                      rdy_oe_b, fb_oe_b, byte_oe_b, rx_valid, rx_overrun, tx_take;
	logic                      cell_mode;
	logic [1:0]                ifc;
	logic [7:0]                n_bytes, cell_rx_byte, rx_byte;
	logic [11:0]               tick = 12'h000;
	pin_share_pkg::eth_iface_t eth_iface;
	int                        miscompares = 0, n_tests = 0, got = 0, lim = 0, ovr = 0, takes = 0;
	// Rows: strap, iface, oe_b of ready, first byte, byte
	localparam logic [5:0] ROWS [5] = '{6'h07, 6'h0f, 6'h13, 6'h1f, 6'h20};

	utopia_emac_pin_sharing utopia_emac_pin_sharing_i (.sys_clk, .rst_b,
		.cell_port_select_strap(sel), .eth_iface_select_strap(ifc), .cell_rx_clk,
		.cell_rx_byte, .tx_cell_ready(), .tx_cell_ready_oe_b(rdy_oe_b), .cell_tx_clk,
		.tx_cell_first_byte(), .tx_cell_first_byte_oe_b(fb_oe_b),
		.tx_cell_first_byte_in(tick[2]), .cell_tx_byte(), .cell_tx_byte_oe_b(byte_oe_b),
		.rx_byte, .rx_valid, .rx_ready, .rx_overrun, .core_cell_waiting(tick[3]),
		.tx_byte(tick[11:4]), .tx_first(tick[4]), .tx_valid(tick[0]), .tx_take,
		.gig_tx_clk_src(tick[1]), .eth_rx_clk(), .eth_rx_nibble_byte(),
		.eth_reduced_rx_bits(), .eth_tx_clk_in(), .reduced_ref_clk(),
		.eth_collision_in(), .cell_mode, .eth_iface);
	cell_master cell_master_i (.go, .n_bytes, .cell_rx_clk, .cell_tx_clk, .cell_rx_byte);

	// ------
	// Tasks
	// ------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic do_reset(input logic s, input logic [1:0] f);
		rst_b <= 1'b0;
		sel <= s;
		ifc <= f;
		repeat (19) @(posedge sys_clk);
		check(cell_mode, 8'h01);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask : do_reset

	task automatic frame(input logic [7:0] n);
		n_bytes <= n;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (n * 16 + 30) @(posedge sys_clk);
	endtask : frame

	// ------
	// Clock, monitor, watchdog
	// ------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (got < lim) check(rx_byte, got[7:0]);
			got++;
		end
		if (rx_overrun === 1'b1) ovr++;
		if (tx_take === 1'b1) takes++;
		tick <= tick + 12'h001;
	end

	initial begin
		#100000;
		miscompares++;
		stop_test();
	end

	// ------
	// Sequence
	// ------
	initial begin
		rst_b = 1'b0;
		sel = 1'b1;
		ifc = 2'h0;
		rx_ready = 1'b1;
		go = 1'b0;
		n_bytes = 8'h00;
		@(posedge sys_clk);
		foreach (ROWS[r]) begin
			do_reset(ROWS[r][5], ROWS[r][4:3]);
			got = 0;
			lim = 99;
			takes = 0;
			frame(8'h06);
			check(cell_mode, ROWS[r][5]);
			check(eth_iface, ROWS[r][4:3]);
			check({rdy_oe_b, fb_oe_b, byte_oe_b}, ROWS[r][2:0]);
			check(got[7:0], ROWS[r][5] ? 8'h06 : 8'h00);
			check(takes > 0, ROWS[r][5]);
		end
		// Fill past the FIFO with the core stalled, then drain
		rx_ready <= 1'b0;
		got = 0;
		lim = 32;
		ovr = 0;
		frame(8'h28);
		check(ovr > 0, 8'h01);
		check(rx_valid, 8'h01);
		rx_ready <= 1'b1;
		repeat (60) @(posedge sys_clk);
		check(got >= 32, 8'h01);
		check(rx_valid, 8'h00);
		stop_test();
	end
endmodule : tb_top
